// ===== bfps_core.sv
// Ballast fault counter and boost switch sequencer, single clock domain.
// Assumes comparator outputs on pins and an on-time length from the analog loop.
// How it works
// RULE1: Fault exits via shutdown high-then-low to preheat
// RULE2: Non-run fault after limit consecutive overcurrent cycles
// RULE3: Overcurrent counts only during low-side on-time
// RULE4: Counter decrements on clean cycles, floors zero
// RULE5: Counter active only in preheat and ignition
// RULE6: Run mode faults on single overcurrent
// RULE7: Boost waits for discharge before turning on
// RULE8: Zero-cross rising edge starts off-time
// RULE9: Zero-cross falling edge starts on-time pulse
// RULE10: Boost disabled by fault, bus limits, undervoltage lockout
// RULE11: Watchdog pulses repeat until edge pair seen
// RULE12: High loop gain preheat/ignition, low in run
// RULE13: Bus over-voltage forces boost drive low
// RULE14: Below regulation after cut-off, watchdog pulse resumes
// RULE15: Fault latches drives low, discharges preheat node
// RULE16: Fault leaves on supply drop or shutdown high
// RULE17: Inputs synchronised; interval from clock rate
`timescale 1ns/1ps
module bfps_core
  import bfps_pkg::*;
#(
  parameter int unsigned LIMIT    = EVENT_LIMIT,
  parameter int unsigned WD_COUNT = RESTART_CYCLES
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Comparator inputs (asynchronous)
  input  wire logic                 supply_ok,         // Supply above undervoltage threshold
  input  wire logic                 preheat_done,      // Preheat timer node past end of preheat
  input  wire logic                 ignition_done,     // Lamp ignited
  input  wire logic                 overcurrent_sense, // Above overcurrent_threshold
  input  wire logic                 shutdown_hi,       // Above shutdown_upper_threshold
  input  wire logic                 shutdown_lo,       // Below shutdown_lower_threshold
  input  wire logic                 zero_cross_sense,  // Zero-cross comparator with hysteresis
  input  wire logic                 bus_ov,            // Above bus_overvoltage_threshold
  input  wire logic                 bus_below_reg,     // Below bus_regulation_reference
  input  wire logic                 bus_uv,            // Bus undervoltage
  // Half-bridge timing from oscillator
  input  wire logic                 low_side_req,      // Oscillator asks low side on
  input  wire logic                 high_side_req,     // Oscillator asks high side on
  // On-time from analog loop
  input  wire logic [ON_TIME_W-1:0] on_time,
  // Outputs
  output logic                      low_side_drive,
  output logic                      high_side_drive,
  output logic                      boost_gate_drive,
  output logic                      preheat_timer_node,  // High discharges the timing node
  output logic                      loop_gain_high,
  output logic [2:0]                mode
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam int WW = $clog2(WD_COUNT + 1);

  // Synchronised inputs
  logic [11:0] s;
  logic sup, phd, ignd, oc, sdh, sdl, zx, ov, breg, buv, lreq, hreq;
  bfps_sync #(.W(12)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in ({supply_ok, preheat_done, ignition_done, overcurrent_sense, shutdown_hi, shutdown_lo,
                zero_cross_sense, bus_ov, bus_below_reg, bus_uv, low_side_req, high_side_req}),
    .sync_out (s)
  ); // RULE17
  assign {sup, phd, ignd, oc, sdh, sdl, zx, ov, breg, buv, lreq, hreq} = s;

  // Ballast state
  bfps_mode_t     mode_ff, nxt_mode;
  logic [CW-1:0]  cnt_ff, nxt_cnt;
  logic           lreq_d_ff, nxt_lreq_d;
  logic           oc_seen_ff, nxt_oc_seen;
  logic           sd_armed_ff, nxt_sd_armed;
  logic           lo_ff, nxt_lo;
  logic           ho_ff, nxt_ho;
  logic           cph_ff, nxt_cph;
  logic           gain_ff, nxt_gain;

  // Counter saturating helpers
  function automatic logic [CW-1:0] dec_floor(input logic [CW-1:0] v);
    return (v == '0) ? v : v - 1'b1;
  endfunction

  logic lo_end;
  assign lo_end = lreq_d_ff && !lreq;

  // Mode sequencing, fault counter and half-bridge gating
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_cnt      = cnt_ff;
    nxt_lreq_d   = lreq;
    nxt_oc_seen  = oc_seen_ff;
    nxt_sd_armed = sd_armed_ff;
    if (lreq && oc) begin
      nxt_oc_seen = 1'b1;                              // RULE3
    end
    if (lo_end) begin
      nxt_oc_seen = 1'b0;
    end
    unique case (mode_ff)
      BFPS_UVLO: begin
        nxt_cnt = '0;
        // After a shutdown exit the pin must also fall below the lower threshold
        if (sup && !sdh && (!sd_armed_ff || sdl)) begin
          nxt_mode     = BFPS_PREHEAT;                 // RULE1
          nxt_sd_armed = 1'b0;
        end
      end
      BFPS_PREHEAT, BFPS_IGNITE: begin
        if (lo_end) begin                              // RULE5
          if (oc_seen_ff) begin
            nxt_cnt = cnt_ff + 1'b1;
          end else begin
            nxt_cnt = dec_floor(cnt_ff);               // RULE4
          end
        end
        if (lo_end && oc_seen_ff && (cnt_ff + 1'b1 >= CW'(LIMIT))) begin
          nxt_mode = BFPS_FAULT;                       // RULE2
        end else if (mode_ff == BFPS_PREHEAT && phd) begin
          nxt_mode = BFPS_IGNITE;
        end else if (mode_ff == BFPS_IGNITE && ignd) begin
          nxt_mode = BFPS_RUN;
        end
      end
      BFPS_RUN: begin
        nxt_cnt = '0;                                  // RULE5
        if (lreq && oc) begin
          nxt_mode = BFPS_FAULT;                       // RULE6
        end
      end
      BFPS_FAULT: begin
        nxt_cnt = '0;
        // Lamp removal leaves fault through lockout; re-insertion restarts from there
        if (sdh) begin
          nxt_mode     = BFPS_UVLO;                    // RULE16
          nxt_sd_armed = 1'b1;
        end
      end
      default: nxt_mode = BFPS_UVLO;
    endcase
    // Supply loss wins over every mode; bus undervoltage wins over run mode only
    if (!sup || (mode_ff == BFPS_RUN && buv)) begin
      nxt_mode     = BFPS_UVLO;                        // RULE16
      nxt_sd_armed = 1'b0;
    end
    nxt_lo   = (nxt_mode inside {BFPS_PREHEAT, BFPS_IGNITE, BFPS_RUN}) && lreq;   // RULE15
    nxt_ho   = (nxt_mode inside {BFPS_PREHEAT, BFPS_IGNITE, BFPS_RUN}) && hreq && !lreq;
    nxt_cph  = (nxt_mode == BFPS_FAULT) || (nxt_mode == BFPS_UVLO);                // RULE15
    nxt_gain = (nxt_mode != BFPS_RUN);                                             // RULE12
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_ff     <= BFPS_UVLO;
      cnt_ff      <= '0;
      lreq_d_ff   <= 1'b0;
      oc_seen_ff  <= 1'b0;
      sd_armed_ff <= 1'b0;
      lo_ff       <= 1'b0;
      ho_ff       <= 1'b0;
      cph_ff      <= 1'b1;
      gain_ff     <= 1'b1;
    end else begin
      mode_ff     <= nxt_mode;
      cnt_ff      <= nxt_cnt;
      lreq_d_ff   <= nxt_lreq_d;
      oc_seen_ff  <= nxt_oc_seen;
      sd_armed_ff <= nxt_sd_armed;
      lo_ff       <= nxt_lo;
      ho_ff       <= nxt_ho;
      cph_ff      <= nxt_cph;
      gain_ff     <= nxt_gain;
    end
  end

  // Boost state
  bfps_boost_t           bst_ff, nxt_bst;
  logic [ON_TIME_W-1:0]  ont_ff, nxt_ont;
  logic [WW-1:0]         wd_ff, nxt_wd;
  logic                  zx_d_ff, nxt_zx_d;
  logic                  ov_lat_ff, nxt_ov_lat;
  logic                  pfc_ff, nxt_pfc;
  logic                  boost_en;
  logic                  zx_rise, zx_fall;

  assign zx_rise  = zx && !zx_d_ff;
  assign zx_fall  = !zx && zx_d_ff;
  // Boost runs only while the ballast is live and the bus is not cut off
  assign boost_en = (mode_ff inside {BFPS_PREHEAT, BFPS_IGNITE, BFPS_RUN}); // RULE10

  // Boost switch sequencing: on-time, off-time, watchdog restart
  always_comb begin
    nxt_bst    = bst_ff;
    nxt_ont    = ont_ff;
    nxt_wd     = wd_ff;
    nxt_zx_d   = zx;
    nxt_ov_lat = ov_lat_ff;
    if (ov) begin
      nxt_ov_lat = 1'b1;                               // RULE13
    end
    if (!boost_en || ov) begin
      nxt_bst = BFPS_B_IDLE;                           // RULE10
      nxt_wd  = '0;
    end else begin
      unique case (bst_ff)
        BFPS_B_IDLE: begin
          // Start via watchdog pulse; after cut-off wait for regulation level
          if (!ov_lat_ff || breg) begin
            nxt_ov_lat = 1'b0;
            nxt_bst    = BFPS_B_ON;                    // RULE14
            nxt_ont    = on_time;
          end
        end
        BFPS_B_ON: begin
          if (ont_ff <= ON_TIME_W'(1)) begin
            nxt_bst = BFPS_B_WAIT;
            nxt_wd  = '0;
          end else begin
            nxt_ont = ont_ff - 1'b1;
          end
        end
        BFPS_B_WAIT, BFPS_B_OFF: begin
          nxt_wd = wd_ff + 1'b1;
          if (zx_rise) begin
            nxt_bst = BFPS_B_OFF;                      // RULE8
          end
          if (bst_ff == BFPS_B_OFF && zx_fall) begin
            nxt_bst = BFPS_B_ON;                       // RULE9
            nxt_ont = on_time;
          end else if (wd_ff >= WW'(WD_COUNT - 1)) begin
            nxt_bst = BFPS_B_ON;                       // RULE11
            nxt_ont = on_time;
          end
        end
      endcase
    end
    nxt_pfc = (nxt_bst == BFPS_B_ON);                  // RULE7
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bst_ff    <= BFPS_B_IDLE;
      ont_ff    <= '0;
      wd_ff     <= '0;
      zx_d_ff   <= 1'b0;
      ov_lat_ff <= 1'b0;
      pfc_ff    <= 1'b0;
    end else begin
      bst_ff    <= nxt_bst;
      ont_ff    <= nxt_ont;
      wd_ff     <= nxt_wd;
      zx_d_ff   <= nxt_zx_d;
      ov_lat_ff <= nxt_ov_lat;
      pfc_ff    <= nxt_pfc;
    end
  end

  assign low_side_drive     = lo_ff;
  assign high_side_drive    = ho_ff;
  assign boost_gate_drive   = pfc_ff;
  assign preheat_timer_node = cph_ff;
  assign loop_gain_high     = gain_ff;
  assign mode               = mode_ff;

  // Checks
  AST_RUN_ONE_EVENT: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == BFPS_RUN && lreq && oc && sup && !buv) |=> mode_ff == BFPS_FAULT) // RULE6
    else $error("run mode missed single overcurrent");
  AST_FAULT_SD_EXIT: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == BFPS_FAULT && sdh) |=> mode_ff == BFPS_UVLO) // RULE16
    else $error("fault mode ignored shutdown rise");
  AST_REINSERT: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == BFPS_UVLO && sd_armed_ff && !sdl) |=> mode_ff != BFPS_PREHEAT) // RULE1
    else $error("preheat restarted before shutdown fell");
  AST_FAULT_DRIVES_LOW: assert property (@(posedge clk) disable iff (reset)
    mode_ff == BFPS_FAULT |=> !lo_ff && !ho_ff && !pfc_ff) // RULE15
    else $error("drives not low in fault");
  AST_FAULT_CPH: assert property (@(posedge clk) disable iff (reset)
    $rose(mode_ff == BFPS_FAULT) |-> cph_ff) // RULE15
    else $error("preheat node not discharged");
  AST_GAIN: assert property (@(posedge clk) disable iff (reset)
    gain_ff == (mode_ff != BFPS_RUN)) // RULE12
    else $error("loop gain wrong for mode");
  AST_OV_OFF: assert property (@(posedge clk) disable iff (reset)
    ov |=> !pfc_ff) // RULE13
    else $error("boost on during over-voltage");
  AST_CNT_RUN: assert property (@(posedge clk) disable iff (reset)
    mode_ff == BFPS_RUN |=> cnt_ff == '0) // RULE5
    else $error("counter active in run");
  AST_CNT_DEC: assert property (@(posedge clk) disable iff (reset)
    (mode_ff == BFPS_PREHEAT && lo_end && !oc_seen_ff && cnt_ff != '0 && sup && !phd)
      |=> cnt_ff == $past(cnt_ff) - 1'b1) // RULE4
    else $error("counter did not decrement");
  sequence s_fall_in_off;
    bst_ff == BFPS_B_OFF && zx_fall && boost_en && !ov;
  endsequence
  AST_ZX_FALL_ON: assert property (@(posedge clk) disable iff (reset)
    s_fall_in_off |=> pfc_ff) // RULE9
    else $error("no on-time after zero-cross fall");
  AST_WD_BOUND: assert property (@(posedge clk) disable iff (reset)
    wd_ff <= WW'(WD_COUNT)) // RULE11
    else $error("watchdog overran interval");
endmodule

// ===== bfps_pkg.sv
// Package for the ballast fault and boost sequencer: modes, counts, timing.
// Assumes a 200 MHz system clock; comparator levels arrive as digital inputs.
package bfps_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned EVENT_LIMIT     = 100;   // Consecutive low-side cycles
  localparam int unsigned RESTART_US      = 400;   // Restart interval in us
  localparam int unsigned RESTART_CYCLES  = (CLK_HZ / 1_000_000) * RESTART_US;
  localparam int unsigned ON_TIME_W       = 16;
  localparam int unsigned SYNC_RESET      = 0;

  // Ballast section modes
  typedef enum logic [2:0] {
    BFPS_UVLO    = 3'h0,
    BFPS_PREHEAT = 3'h1,
    BFPS_IGNITE  = 3'h2,
    BFPS_RUN     = 3'h3,
    BFPS_FAULT   = 3'h4
  } bfps_mode_t;

  // Boost switch states
  typedef enum logic [1:0] {
    BFPS_B_IDLE = 2'h0,
    BFPS_B_ON   = 2'h1,
    BFPS_B_OFF  = 2'h2,
    BFPS_B_WAIT = 2'h3
  } bfps_boost_t;
endpackage

// ===== bfps_sync.sv
// Three-stage synchroniser with agreement filter for comparator inputs.
// Assumes inputs are asynchronous levels from analog comparators.
`timescale 1ns/1ps
module bfps_sync
  import bfps_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] out_ff;
  logic [W-1:0] nxt_out;

  // Accept a change only once stages two and three agree
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_ff  <= '0;
      s2_ff  <= '0;
      s3_ff  <= '0;
      out_ff <= '0;
    end else begin
      s1_ff  <= async_in;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule

// ===== bfps_far_model.sv
// Far-side model: half-bridge oscillator requests and boost zero-cross winding.
// Assumes the system clock; zx_stuck holds the winding high so no falling edge comes.
`timescale 1ns/1ps
module bfps_far_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Bench control and observed gate
  input  wire logic zx_stuck,
  input  wire logic boost_gate_drive,
  // Requests and sense
  output logic      low_side_req,
  output logic      high_side_req,
  output logic      zero_cross_sense
);
  logic [5:0] osc_ff;
  logic [5:0] zx_ff;
  logic       gate_ff;

  // Oscillator: low side 0..15, deadtime, high side 20..35, deadtime
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      osc_ff <= 6'h00;
    end else begin
      osc_ff <= (osc_ff == 6'h27) ? 6'h00 : osc_ff + 6'h01;
    end
  end
  assign low_side_req  = (osc_ff < 6'h10);
  assign high_side_req = (osc_ff >= 6'h14) && (osc_ff < 6'h24);

  // Winding rises after gate off and falls once discharged; restart only from idle
  // so a watchdog pulse during a stuck winding never fakes a falling edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gate_ff <= 1'b0;
      zx_ff   <= 6'h00;
    end else begin
      gate_ff <= boost_gate_drive;
      if (gate_ff && !boost_gate_drive && zx_ff == 6'h00) begin
        zx_ff <= 6'h01;
      end else if (zx_ff != 6'h00 && !(zx_stuck && zx_ff == 6'h18)) begin
        zx_ff <= (zx_ff == 6'h18) ? 6'h00 : zx_ff + 6'h01;
      end
    end
  end
  assign zero_cross_sense = (zx_ff >= 6'h03);
endmodule

// ===== bfps_core_tb_top.sv
// Self-checking bench for the ballast fault and boost sequencer core.
// Assumes the far-side model drives the oscillator and zero-cross lines.
`timescale 1ns/1ps
module bfps_core_tb_top;
  import bfps_pkg::*;
  localparam int LIM = 5;   // Short fault limit keeps the run brief
  localparam int WD  = 200; // Short restart interval keeps the run brief
  logic        clk, reset, supply_ok, preheat_done, ignition_done, overcurrent_sense, shutdown_hi;
  logic        shutdown_lo, bus_ov, bus_below_reg, bus_uv, zx_stuck, low_side_req, high_side_req;
  logic        zero_cross_sense, low_side_drive, high_side_drive, boost_gate_drive;
  logic        preheat_timer_node, loop_gain_high;
  logic [15:0] on_time;
  logic [2:0]  mode;
  int          failures, comparisons, rises, mingap, maxgap;

  bfps_core #(.LIMIT(LIM), .WD_COUNT(WD)) dut (
    .clk, .reset, .supply_ok, .preheat_done, .ignition_done, .overcurrent_sense, .shutdown_hi,
    .shutdown_lo, .zero_cross_sense, .bus_ov, .bus_below_reg, .bus_uv, .low_side_req, .high_side_req,
    .on_time, .low_side_drive, .high_side_drive, .boost_gate_drive, .preheat_timer_node,
    .loop_gain_high, .mode
  );
  bfps_far_model far (.clk, .reset, .zx_stuck, .boost_gate_drive, .low_side_req, .high_side_req,
    .zero_cross_sense);

  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Bounded wait for a mode; a miss ends the run
  task automatic wait_mode(input logic [2:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(mode), 16'(m));
    if (mode !== m) conclude();
  endtask

  // One low-side phase with overcurrent held for 8 cycles from dly after its start
  task automatic phase(input logic oc, input int dly);
    int n;
    n = 0;
    while (low_side_req !== 1'b0 && n < 99) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (low_side_req !== 1'b1 && n < 99) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 99) begin
      failures++;
      conclude();
    end
    repeat (dly) @(posedge clk);
    overcurrent_sense <= oc;
    repeat (8) @(posedge clk);
    overcurrent_sense <= 1'b0;
  endtask

  // Counts boost pulses and the spacing of their rising edges
  task automatic watch(input int cyc);
    int   last;
    logic prev;
    last = -1;
    prev = boost_gate_drive;
    rises = 0;
    mingap = 99999;
    maxgap = 0;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk);
      #1;
      if (boost_gate_drive === 1'b1 && prev === 1'b0) begin
        if (!zx_stuck) chk(16'(zero_cross_sense), 16'h0000);
        if (last >= 0) mingap = (i - last < mingap) ? i - last : mingap;
        if (last >= 0) maxgap = (i - last > maxgap) ? i - last : maxgap;
        last = i;
        rises++;
      end
      prev = boost_gate_drive;
    end
  endtask

  // Off-phase events ignored, isolated bursts decay, limit run of events faults
  task automatic t_count();
    for (int i = 0; i < 8; i++) phase(1'b1, 18);
    for (int i = 0; i < 3 * (LIM - 1); i++) phase(i < LIM - 1 || i >= 2 * (LIM - 1), 2);
    repeat (20) @(posedge clk);
    #1;
    chk(16'(mode), 16'(BFPS_PREHEAT));
    phase(1'b1, 2);
    wait_mode(BFPS_FAULT, 40);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1;
      chk(16'({low_side_drive, high_side_drive, boost_gate_drive, preheat_timer_node}), 16'h0001);
    end
  endtask

  // Lamp removal then re-insertion
  task automatic t_exit();
    @(posedge clk);
    shutdown_hi <= 1'b1;
    wait_mode(BFPS_UVLO, 30);
    @(posedge clk);
    shutdown_hi <= 1'b0;
    shutdown_lo <= 1'b1;
    wait_mode(BFPS_PREHEAT, 30);
    chk(16'(preheat_timer_node), 16'h0000);
    @(posedge clk);
    shutdown_lo <= 1'b0;
  endtask

  // Stuck winding gives spaced watchdog pulses, then normal switching returns
  task automatic t_watchdog();
    @(posedge clk);
    zx_stuck <= 1'b1;
    watch(100);
    watch(1000);
    chk(16'(rises >= 4), 16'h0001);
    chk(16'(mingap >= WD && maxgap <= WD + 30), 16'h0001);
    @(posedge clk);
    zx_stuck <= 1'b0;
    watch(300);
    chk(16'(rises >= 3), 16'h0001);
  endtask

  // Over-voltage holds the gate low; restart waits for the regulation level
  task automatic t_ov();
    @(posedge clk);
    bus_ov <= 1'b1;
    repeat (8) @(posedge clk);
    watch(300);
    chk(16'({rises[7:0], boost_gate_drive}), 16'h0000);
    @(posedge clk);
    bus_ov <= 1'b0;
    watch(250);
    chk(16'(rises), 16'h0000);
    @(posedge clk);
    bus_below_reg <= 1'b1;
    watch(20);
    chk(16'(rises), 16'h0001);
  endtask

  // Gain follows mode; run mode faults on one event
  task automatic t_run();
    @(posedge clk);
    preheat_done <= 1'b1;
    wait_mode(BFPS_IGNITE, 30);
    chk(16'(loop_gain_high), 16'h0001);
    @(posedge clk);
    ignition_done <= 1'b1;
    wait_mode(BFPS_RUN, 30);
    chk(16'(loop_gain_high), 16'h0000);
    phase(1'b1, 2);
    wait_mode(BFPS_FAULT, 40);
  endtask

  initial begin
    failures = 0;
    comparisons = 0;
    reset = 1'b1;
    on_time = 16'h000a;
    {supply_ok, preheat_done, ignition_done, overcurrent_sense, shutdown_hi} = 5'h00;
    {shutdown_lo, bus_ov, bus_below_reg, bus_uv, zx_stuck} = 5'h00;
    repeat (12) @(posedge clk);
    #1;
    chk(16'({low_side_drive, high_side_drive, boost_gate_drive}), 16'h0000);
    chk(16'({preheat_timer_node, loop_gain_high, mode}), 16'h0018);
    @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    supply_ok <= 1'b1;
    wait_mode(BFPS_PREHEAT, 30);
    chk(16'(loop_gain_high), 16'h0001);
    t_count();
    t_exit();
    watch(300);
    chk(16'(rises >= 3), 16'h0001);
    t_watchdog();
    t_ov();
    t_run();
    conclude();
  end
endmodule
